// file: isa_port_defines.svh
`ifndef ISA_PORT_DEFINES_SVH
`define ISA_PORT_DEFINES_SVH
// i/o window: 16 bases spaced 32 bytes apart, 24 bytes each
`define WIN_BASE_FIRST 16'h0200
`define WIN_BYTES 16'h0018
`define WIN_OFF_PROM_END 16'h0010
`define WIN_OFF_RPTR 16'h0010
`define WIN_OFF_IDATA 16'h0016
// indirect register numbers reached through the pointer port
`define CSR_SRAM_PTR 4'h0
`define CSR_SRAM_DATA 4'h1
`define CSR_CFG_TWO 4'h2
`define CFG_TWO_ACCESS_SEL_BIT 13
`define CFG_TWO_RESET 16'h0000
// auto-configuration ports, 12-bit decode
`define CFG_INDEX_ADDR 12'h279
`define CFG_WDATA_ADDR 12'ha79
`define CFG_REG_RD_PORT 8'h00
`define CFG_REG_CTRL 8'h02
`define CFG_CTRL_WAIT_KEY_BIT 1
`define CFG_REG_ACTIVATE 8'h30
`define KEY_SEED 8'h6a
`define KEY_LAST 5'h1f
`define ADDR_PROM_FILL 8'h00
// bus idle read value
`define BUS_FLOAT 16'hffff
// host-side decode of the board's memory resources
`define HOST_BOOT_BASE 24'h0c_8000
`define HOST_BOOT_SIZE 24'h00_4000
`define HOST_SHM_BASE 24'h0d_0000
`define HOST_SHM_SIZE 24'h00_1000
`define HOST_CS16_SEG 7'h06
`endif

// file: isa_port_pkg.sv
`default_nettype none
package isa_port_pkg;
   // byte engine of the device end
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_GRAB} eng_state_t;
   // cycle sequencer of the host end
   typedef enum logic [1:0] {HS_IDLE, HS_BUSY} host_state_t;
endpackage : isa_port_pkg
`default_nettype wire

// file: isa_port_if.sv
`default_nettype none
interface isa_port_if;
   logic [23:0] sa;
   logic [15:0] hd;
   logic io_rd;
   logic io_wr;
   logic mem_rd;
   logic mem_wr;
   logic word16;
   logic boot_prom_match_in_n;
   logic shared_mem_match_in_n;
   logic mem_cs16;
   logic [15:0] dd;
   logic dd_oe;
   logic ack;
   modport dev (
      input sa, hd, io_rd, io_wr, mem_rd, mem_wr, word16,
      input boot_prom_match_in_n, shared_mem_match_in_n, mem_cs16,
      output dd, dd_oe, ack
   );
   modport host (
      output sa, hd, io_rd, io_wr, mem_rd, mem_wr, word16,
      output boot_prom_match_in_n, shared_mem_match_in_n, mem_cs16,
      input dd, dd_oe, ack
   );
endinterface : isa_port_if
`default_nettype wire

// file: isa_slave_port.sv
`include "isa_port_defines.svh"
`default_nettype none
module isa_slave_port
   import isa_port_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   isa_port_if.dev bus,
   input wire logic master_strap,
   input wire logic net_boot_strap,
   input wire logic [3:0] io_base_sel,
   input wire logic [10:0] boot_base,
   input wire logic [1:0] boot_size,
   output logic [15:0] prom_addr,
   input wire logic [7:0] prom_data,
   output logic bus_master_mode,
   output logic config_mode
);
   logic strap_done_reg, master_reg, active_reg, cfg_mode_reg, served_reg, ack_reg, oe_reg;
   logic [3:0] base_sel_reg, rptr_reg;
   logic [10:0] boot_base_reg;
   logic [1:0] boot_size_reg;
   logic [11:0] ptr_reg, pf_addr_reg;
   logic [15:0] cfg_two_reg, pf_data_reg, asm_reg, wdat_reg, byte_addr_reg, rdata_reg;
   logic [7:0] cfg_index_reg, rd_port_reg, key_reg, sram_q;
   logic [4:0] key_cnt_reg;
   logic pf_valid_reg, op_pf_reg, op_prom_reg, op_wr_reg, op_two_reg, hi_reg;
   eng_state_t state_reg;
   logic [7:0] sram [0:4095];

   logic is_io, is_wr, req, in_win, win_hit, pio_sel, pio_sram, prom_sel, shm_sel, mem_prom, mem_shm;
   logic sram_go, pf_hit, idx_hit, wdat_hit, rdat_hit, last_byte;
   logic [15:0] win_off, reg_rdata, asm_next;
   logic [11:0] sram_addr;
   logic [10:0] size_mask;
   logic [7:0] byte_in, cfg_rd;

   assign prom_addr = byte_addr_reg;
   assign bus_master_mode = master_reg;
   assign config_mode = cfg_mode_reg;
   assign bus.dd = rdata_reg;
   assign bus.dd_oe = oe_reg;
   assign bus.ack = ack_reg;

   // straps are caught on the first edge after release, never by the reset itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_reg <= 1'b0;
         master_reg <= 1'b0;
         base_sel_reg <= 4'h0;
         boot_base_reg <= 11'h000;
         boot_size_reg <= 2'b00;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         master_reg <= master_strap;
         base_sel_reg <= io_base_sel;
         boot_base_reg <= boot_base;
         boot_size_reg <= boot_size;
      end
   end

   // address decode of the request now on the bus
   always_comb begin
      is_io = bus.io_rd | bus.io_wr;
      is_wr = bus.io_wr | bus.mem_wr;
      req = (is_io | bus.mem_rd | bus.mem_wr) & ~served_reg & ~ack_reg & (state_reg == ST_IDLE);
      win_off = bus.sa[15:0] - (`WIN_BASE_FIRST + {7'h00, base_sel_reg, 5'h00});
      in_win = active_reg & (win_off < `WIN_BYTES);
      win_hit = is_io & in_win;
      pio_sel = ~master_reg & cfg_two_reg[`CFG_TWO_ACCESS_SEL_BIT];
      pio_sram = win_hit & (win_off == `WIN_OFF_IDATA) & (rptr_reg == `CSR_SRAM_DATA) & pio_sel;
      size_mask = 11'h7ff << boot_size_reg;
      // masters decode the prom themselves, slaves trust the board decoder
      prom_sel = master_reg ? (((bus.sa[23:13] ^ boot_base_reg) & size_mask) == 11'h000)
                            : ~bus.boot_prom_match_in_n;
      shm_sel = ~master_reg & ~pio_sel & ~bus.shared_mem_match_in_n;
      mem_prom = ~is_io & active_reg & prom_sel & ~is_wr;
      mem_shm = ~is_io & active_reg & shm_sel & ~mem_prom;
      sram_go = req & (pio_sram | mem_shm);
      sram_addr = pio_sram ? ptr_reg : bus.sa[11:0];
      if (bus.word16) begin
         sram_addr[0] = 1'b0;
      end
      pf_hit = sram_go & ~is_wr & bus.word16 & pf_valid_reg & (pf_addr_reg == sram_addr);
      idx_hit = is_io & (bus.sa[11:0] == `CFG_INDEX_ADDR);
      wdat_hit = bus.io_wr & cfg_mode_reg & (bus.sa[11:0] == `CFG_WDATA_ADDR);
      rdat_hit = bus.io_rd & cfg_mode_reg & (bus.sa[11:0] == {2'b00, rd_port_reg, 2'b11});
      case (cfg_index_reg)
         `CFG_REG_RD_PORT: cfg_rd = rd_port_reg;
         `CFG_REG_ACTIVATE: cfg_rd = {7'h00, active_reg};
         default: cfg_rd = 8'h00;
      endcase
      if (rdat_hit) begin
         reg_rdata = {8'h00, cfg_rd};
      end else if (win_off < `WIN_OFF_PROM_END) begin
         reg_rdata = {8'h00, `ADDR_PROM_FILL};
      end else if (win_off == `WIN_OFF_RPTR) begin
         reg_rdata = {12'h000, rptr_reg};
      end else if (win_off == `WIN_OFF_IDATA && rptr_reg == `CSR_SRAM_PTR) begin
         reg_rdata = {4'h0, ptr_reg};
      end else if (win_off == `WIN_OFF_IDATA && rptr_reg == `CSR_CFG_TWO) begin
         reg_rdata = cfg_two_reg;
      end else begin
         reg_rdata = 16'h0000;
      end
      byte_in = op_prom_reg ? prom_data : sram_q;
      asm_next = hi_reg ? {byte_in, asm_reg[7:0]} : {8'h00, byte_in};
      last_byte = ~op_two_reg | hi_reg;
   end

   // window registers: pointer port, sram pointer, second config register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rptr_reg <= 4'h0;
         ptr_reg <= 12'h000;
         cfg_two_reg <= `CFG_TWO_RESET;
      end else if (sram_go & pio_sram) begin
         ptr_reg <= ptr_reg + (bus.word16 ? 12'h002 : 12'h001);
      end else if (req & win_hit & bus.io_wr) begin
         if (win_off == `WIN_OFF_RPTR) begin
            rptr_reg <= bus.hd[3:0];
         end else if (win_off == `WIN_OFF_IDATA && rptr_reg == `CSR_SRAM_PTR) begin
            ptr_reg <= bus.hd[11:0];
         end else if (win_off == `WIN_OFF_IDATA && rptr_reg == `CSR_CFG_TWO) begin
            cfg_two_reg <= bus.hd;
         end
      end
   end

   // auto-configuration: index, key detector, read-port place, activation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_index_reg <= 8'h00;
         rd_port_reg <= 8'h00;
         key_reg <= `KEY_SEED;
         key_cnt_reg <= 5'h00;
         cfg_mode_reg <= 1'b0;
         active_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         active_reg <= net_boot_strap;
      end else if (req & idx_hit) begin
         if (bus.io_wr) begin
            cfg_index_reg <= bus.hd[7:0];
         end
         // only an unbroken run of the exact pattern opens config mode
         if (bus.io_wr && bus.hd[7:0] == key_reg) begin
            key_reg <= {key_reg[1] ^ key_reg[0], key_reg[7:1]};
            key_cnt_reg <= key_cnt_reg + 5'h01;
            if (key_cnt_reg == `KEY_LAST) begin
               cfg_mode_reg <= 1'b1;
               key_reg <= `KEY_SEED;
            end
         end else begin
            key_reg <= `KEY_SEED;
            key_cnt_reg <= 5'h00;
         end
      end else if (req & wdat_hit) begin
         case (cfg_index_reg)
            `CFG_REG_RD_PORT: rd_port_reg <= bus.hd[7:0];
            `CFG_REG_ACTIVATE: active_reg <= bus.hd[0];
            `CFG_REG_CTRL: cfg_mode_reg <= ~bus.hd[`CFG_CTRL_WAIT_KEY_BIT];
            default: cfg_mode_reg <= cfg_mode_reg;
         endcase
      end
   end

   // local sram: registered read, byte writes from the engine
   always_ff @(posedge mclk) begin
      if (state_reg == ST_WAIT && op_wr_reg) begin
         sram[byte_addr_reg[11:0]] <= hi_reg ? wdat_reg[15:8] : wdat_reg[7:0];
      end
      sram_q <= sram[byte_addr_reg[11:0]];
   end

   // a strobe is answered once; wait for it to drop before taking another
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         served_reg <= 1'b0;
      end else if (ack_reg) begin
         served_reg <= 1'b1;
      end else if (!(is_io | bus.mem_rd | bus.mem_wr)) begin
         served_reg <= 1'b0;
      end
   end

   // byte engine: splits words into byte accesses, answers, prefetches
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         byte_addr_reg <= 16'h0000;
         asm_reg <= 16'h0000;
         wdat_reg <= 16'h0000;
         op_pf_reg <= 1'b0;
         op_prom_reg <= 1'b0;
         op_wr_reg <= 1'b0;
         op_two_reg <= 1'b0;
         hi_reg <= 1'b0;
         pf_valid_reg <= 1'b0;
         pf_addr_reg <= 12'h000;
         pf_data_reg <= 16'h0000;
      end else begin
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (pf_hit) begin
                  // zero-wait answer, then fetch the following word
                  ack_reg <= 1'b1;
                  oe_reg <= 1'b1;
                  rdata_reg <= pf_data_reg;
                  pf_valid_reg <= 1'b0;
                  pf_addr_reg <= pf_addr_reg + 12'h002;
                  byte_addr_reg <= {4'h0, pf_addr_reg + 12'h002};
                  op_pf_reg <= 1'b1;
                  op_prom_reg <= 1'b0;
                  op_wr_reg <= 1'b0;
                  op_two_reg <= 1'b1;
                  hi_reg <= 1'b0;
                  state_reg <= ST_WAIT;
               end else if (sram_go | (req & mem_prom)) begin
                  // no answer until the bytes are in: the host cycle stretches
                  op_pf_reg <= 1'b0;
                  op_prom_reg <= mem_prom;
                  op_wr_reg <= is_wr;
                  op_two_reg <= bus.word16;
                  hi_reg <= 1'b0;
                  wdat_reg <= bus.hd;
                  byte_addr_reg <= mem_prom ? {bus.sa[15:1], bus.sa[0] & ~bus.word16} : {4'h0, sram_addr};
                  if (is_wr) begin
                     pf_valid_reg <= 1'b0;
                  end
                  state_reg <= ST_WAIT;
               end else if (req) begin
                  // other cycles end at once; only window and read-data port reads drive the data
                  ack_reg <= 1'b1;
                  oe_reg <= ~is_wr & (win_hit | rdat_hit);
                  rdata_reg <= reg_rdata;
               end
            end
            ST_WAIT: begin
               if (!op_wr_reg) begin
                  state_reg <= ST_GRAB;
               end else if (!last_byte) begin
                  hi_reg <= 1'b1;
                  byte_addr_reg <= byte_addr_reg + 16'h0001;
               end else begin
                  ack_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_GRAB: begin
               asm_reg <= asm_next;
               if (!last_byte) begin
                  hi_reg <= 1'b1;
                  byte_addr_reg <= byte_addr_reg + 16'h0001;
                  state_reg <= ST_WAIT;
               end else if (op_pf_reg) begin
                  pf_data_reg <= asm_next;
                  pf_valid_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end else begin
                  ack_reg <= 1'b1;
                  oe_reg <= 1'b1;
                  rdata_reg <= asm_next;
                  state_reg <= ST_IDLE;
                  if (!op_prom_reg && op_two_reg) begin
                     pf_addr_reg <= byte_addr_reg[11:0] + 12'h001;
                     byte_addr_reg <= byte_addr_reg + 16'h0001;
                     op_pf_reg <= 1'b1;
                     hi_reg <= 1'b0;
                     state_reg <= ST_WAIT;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule : isa_slave_port
`default_nettype wire

// file: isa_host_end.sv
`include "isa_port_defines.svh"
`default_nettype none
module isa_host_end
   import isa_port_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   isa_port_if.host bus,
   input wire logic cmd_valid,
   input wire logic cmd_io,
   input wire logic cmd_write,
   input wire logic cmd_word,
   input wire logic [23:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   input wire logic pio_mode,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_data
);
   host_state_t state_reg;
   logic [23:0] sa_reg;
   logic [15:0] hd_reg;
   logic io_rd_reg, io_wr_reg, mem_rd_reg, mem_wr_reg, word_reg, boot_n_reg, shm_n_reg, cs16_reg;
   logic in_boot, in_shm;

   assign bus.sa = sa_reg;
   assign bus.hd = hd_reg;
   assign bus.io_rd = io_rd_reg;
   assign bus.io_wr = io_wr_reg;
   assign bus.mem_rd = mem_rd_reg;
   assign bus.mem_wr = mem_wr_reg;
   assign bus.word16 = word_reg;
   assign bus.boot_prom_match_in_n = boot_n_reg;
   assign bus.shared_mem_match_in_n = shm_n_reg;
   assign bus.mem_cs16 = cs16_reg;
   assign cmd_ready = (state_reg == HS_IDLE);

   // board decoder for the boot prom and the shared sram window
   always_comb begin
      in_boot = ~cmd_io & (cmd_addr >= `HOST_BOOT_BASE) & (cmd_addr < `HOST_BOOT_BASE + `HOST_BOOT_SIZE);
      in_shm = ~cmd_io & (cmd_addr >= `HOST_SHM_BASE) & (cmd_addr < `HOST_SHM_BASE + `HOST_SHM_SIZE);
   end

   // one bus cycle at a time: strobes stand until the device answers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= HS_IDLE;
         sa_reg <= 24'h00_0000;
         hd_reg <= 16'h0000;
         io_rd_reg <= 1'b0;
         io_wr_reg <= 1'b0;
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         word_reg <= 1'b0;
         boot_n_reg <= 1'b1;
         shm_n_reg <= 1'b1;
         cs16_reg <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
      end else begin
         rsp_valid <= 1'b0;
         case (state_reg)
            HS_IDLE: begin
               if (cmd_valid) begin
                  sa_reg <= cmd_addr;
                  hd_reg <= cmd_wdata;
                  word_reg <= cmd_word;
                  io_rd_reg <= cmd_io & ~cmd_write;
                  io_wr_reg <= cmd_io & cmd_write;
                  mem_rd_reg <= ~cmd_io & ~cmd_write;
                  mem_wr_reg <= ~cmd_io & cmd_write;
                  boot_n_reg <= ~in_boot;
                  shm_n_reg <= pio_mode | ~in_shm;
                  cs16_reg <= ~cmd_io & (cmd_addr[23:17] == `HOST_CS16_SEG);
                  state_reg <= HS_BUSY;
               end
            end
            HS_BUSY: begin
               if (bus.ack) begin
                  io_rd_reg <= 1'b0;
                  io_wr_reg <= 1'b0;
                  mem_rd_reg <= 1'b0;
                  mem_wr_reg <= 1'b0;
                  boot_n_reg <= 1'b1;
                  shm_n_reg <= 1'b1;
                  cs16_reg <= 1'b0;
                  rsp_valid <= 1'b1;
                  rsp_data <= bus.dd_oe ? bus.dd : `BUS_FLOAT;
                  state_reg <= HS_IDLE;
               end
            end
            default: state_reg <= HS_IDLE;
         endcase
      end
   end
endmodule : isa_host_end
`default_nettype wire

// file: isa_port_asserts.sv
`default_nettype none
module isa_port_asserts (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [23:0] sa,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic word16,
   input wire logic boot_prom_match_in_n,
   input wire logic shared_mem_match_in_n,
   input wire logic mem_cs16,
   input wire logic dd_oe,
   input wire logic ack
);
   logic strobe;
   logic [7:0] wait_reg;
   assign strobe = io_rd | io_wr | mem_rd | mem_wr;
   // edges a live cycle has waited; saturates so a hang cannot wrap back to a small count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 8'h00;
      end else if (ack || !strobe) begin
         wait_reg <= 8'h00;
      end else if (wait_reg != 8'hff) begin
         wait_reg <= wait_reg + 8'h01;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence s_cycle_start;
      $rose(strobe);
   endsequence
   sequence s_prom_word_done;
      ack && dd_oe && mem_rd && word16 && !boot_prom_match_in_n;
   endsequence
   sequence s_cfg_port_rd;
      io_rd && ack && (sa[11:0] == 12'h279 || sa[11:0] == 12'ha79);
   endsequence
   a_ack_single: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_ack_bounded: assert property (s_cycle_start |-> ##[1:12] ack)
      else $error("bus cycle never acknowledged");
   a_ack_in_cycle: assert property (ack |-> strobe)
      else $error("ack without a live cycle");
   a_oe_read_only: assert property (dd_oe |-> ack && (io_rd || mem_rd))
      else $error("data driven outside a read ack");
   a_prom_two_bytes: assert property (s_prom_word_done |-> wait_reg >= 8'd4)
      else $error("prom word read too short for two bytes");
   a_mem_no_match: assert property (mem_rd && ack && boot_prom_match_in_n && shared_mem_match_in_n |-> !dd_oe)
      else $error("memory read claimed without a match");
   a_cfg_write_only: assert property (s_cfg_port_rd |-> !dd_oe)
      else $error("write-only config port drove data");
   a_host_holds: assert property (strobe && !ack |=> strobe && $stable(sa))
      else $error("host request changed before ack");
   a_cs16_segment: assert property ((mem_rd || mem_wr) |-> mem_cs16 == (sa[23:17] == 7'h06))
      else $error("memcs16 does not follow segment decode");
endmodule : isa_port_asserts
`default_nettype wire

// file: isa_slave_access_and_autoconfig_ports_tb.sv
`include "isa_port_defines.svh"
`default_nettype none
module isa_slave_access_and_autoconfig_ports_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, master_strap, net_boot_strap, pio_mode, bus_master_mode, config_mode;
   logic cmd_valid, cmd_io, cmd_write, cmd_word, cmd_ready, rsp_valid;
   logic [3:0] io_base_sel;
   logic [7:0] prom_data, key;
   logic [15:0] prom_addr, rsp_data, rdata, w0, w1, cmd_wdata, offs;
   logic [23:0] cmd_addr, win, sa_a, pb;
   int err_count, checks, lat, lat_miss, seed;
   isa_port_if bus ();
   isa_slave_port u_isa_slave_port (.mclk(mclk), .rst_n(rst_n), .bus(bus.dev), .master_strap(master_strap),
      .net_boot_strap(net_boot_strap), .io_base_sel(io_base_sel), .boot_base(11'h064), .boot_size(2'h1),
      .prom_addr(prom_addr), .prom_data(prom_data), .bus_master_mode(bus_master_mode), .config_mode(config_mode));
   isa_host_end u_isa_host_end (.mclk(mclk), .rst_n(rst_n), .bus(bus.host), .cmd_valid(cmd_valid), .cmd_io(cmd_io),
      .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .pio_mode(pio_mode),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   isa_port_asserts u_isa_port_asserts (.mclk(mclk), .rst_n(rst_n), .sa(bus.sa), .io_rd(bus.io_rd),
      .io_wr(bus.io_wr), .mem_rd(bus.mem_rd), .mem_wr(bus.mem_wr), .word16(bus.word16),
      .boot_prom_match_in_n(bus.boot_prom_match_in_n), .shared_mem_match_in_n(bus.shared_mem_match_in_n),
      .mem_cs16(bus.mem_cs16), .dd_oe(bus.dd_oe), .ack(bus.ack));
   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // only the low address byte shapes prom content, so the window offset mapping cannot matter
   function automatic logic [7:0] prom_byte(input logic [15:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction : prom_byte
   // board prom: one register stage, the most the engine's single wait cycle allows
   always @(posedge mclk) prom_data <= prom_byte(prom_addr);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   // one host command; lat counts edges from acceptance to response
   task automatic xfer(input logic io, input logic wr, input logic wd, input logic [23:0] a, input logic [15:0] w);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      {cmd_io, cmd_write, cmd_word, cmd_addr, cmd_wdata} <= {io, wr, wd, a, w};
      @(posedge mclk);
      cmd_valid <= 1'b0;
      lat = 0;
      do begin
         @(posedge mclk);
         #1;
         lat++;
      end while (rsp_valid !== 1'b1 && lat < 40);
      if (lat >= 40) chk(16'hdead, 16'h0000);
      rdata = rsp_data;
      chk({15'h0000, cmd_ready}, 16'h0001);
   endtask : xfer
   task automatic do_reset(input logic ms, input logic nb);
      @(posedge mclk);
      rst_n <= 1'b0;
      master_strap <= ms;
      net_boot_strap <= nb;
      io_base_sel <= 4'($random(seed)) | 4'h1;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      win = 24'h00_0200 + 24'(io_base_sel) * 24'h00_0020;
      chk({15'h0000, bus_master_mode}, {15'h0000, ms});
   endtask : do_reset
   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, 1'b1, 1'b0, 24'h00_0279, {8'h00, idx});
      xfer(1'b1, 1'b1, 1'b0, 24'h00_0a79, {8'h00, d});
   endtask : cfg_wr
   // key writes use varied upper address nibbles; brk places an interrupting read, 32 means none
   task automatic send_key(input int brk);
      key = `KEY_SEED;
      for (int i = 0; i < 32; i++) begin
         if (i == brk) xfer(1'b1, 1'b0, 1'b0, 24'h00_0279, 16'h0000);
         xfer(1'b1, 1'b1, 1'b0, {8'h00, 4'(i), 12'h279}, {8'h00, key});
         key = {key[1] ^ key[0], key[7:1]};
      end
   endtask : send_key
   // pointer port select, then one data-port access
   task automatic pio(input logic [3:0] r, input logic wr, input logic wd, input logic [15:0] w);
      xfer(1'b1, 1'b1, 1'b0, win + 24'h00_0010, {12'h000, r});
      xfer(1'b1, wr, wd, win + 24'h00_0016, w);
   endtask : pio
   // hang guard, sized well above the expected run
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      end_sim();
   end
   initial begin
      seed = 32'hef2f;
      {err_count, checks} = '0;
      {rst_n, master_strap, net_boot_strap, pio_mode, cmd_valid, cmd_io, cmd_write, cmd_word} = '0;
      {io_base_sel, cmd_addr, cmd_wdata} = '0;
      prom_data = 8'h00;
      // master strap, no network boot: silent until keyed and activated
      do_reset(1'b1, 1'b0);
      xfer(1'b1, 1'b0, 1'b0, win, 16'h0000);
      chk(rdata, `BUS_FLOAT);
      send_key(10);
      chk({15'h0000, config_mode}, 16'h0000);
      send_key(32);
      chk({15'h0000, config_mode}, 16'h0001);
      cfg_wr(`CFG_REG_RD_PORT, 8'h80);
      cfg_wr(`CFG_REG_ACTIVATE, 8'h01);
      repeat (2) begin
         xfer(1'b1, 1'b0, 1'b0, 24'h00_0203, 16'h0000);
         chk({8'h00, rdata[7:0]}, 16'h0001);
      end
      chk({15'h0000, bus_master_mode}, 16'h0001);
      xfer(1'b1, 1'b0, 1'b0, win, 16'h0000);
      chk({8'h00, rdata[7:0]}, {8'h00, `ADDR_PROM_FILL});
      // a master decodes its 16K prom itself; the next 16K block must stay silent
      pb = 24'h0c_8000 + 24'(16'($random(seed)) & 16'h3ffe);
      xfer(1'b0, 1'b0, 1'b1, pb, 16'h0000);
      chk(rdata, {prom_byte(pb[15:0] + 16'h0001), prom_byte(pb[15:0])});
      xfer(1'b0, 1'b0, 1'b1, pb + 24'h00_4000, 16'h0000);
      chk(rdata, `BUS_FLOAT);
      // leaving config mode takes the read-data port off the bus
      cfg_wr(`CFG_REG_CTRL, 8'h02);
      chk({15'h0000, config_mode}, 16'h0000);
      xfer(1'b1, 1'b0, 1'b0, 24'h00_0203, 16'h0000);
      chk(rdata, `BUS_FLOAT);
      // slave strap with network boot: active from reset, shared memory by default
      do_reset(1'b0, 1'b1);
      xfer(1'b1, 1'b0, 1'b0, win, 16'h0000);
      chk({8'h00, rdata[7:0]}, {8'h00, `ADDR_PROM_FILL});
      xfer(1'b1, 1'b0, 1'b0, win + 24'h00_0018, 16'h0000);
      chk(rdata, `BUS_FLOAT);
      offs = 16'($random(seed)) & 16'h07fe;
      sa_a = 24'h0d_0000 + 24'(offs);
      w0 = 16'($random(seed));
      w1 = 16'($random(seed));
      xfer(1'b0, 1'b1, 1'b1, sa_a, w0);
      xfer(1'b0, 1'b1, 1'b1, sa_a + 24'h00_0002, w1);
      repeat (6) @(posedge mclk);
      xfer(1'b0, 1'b0, 1'b1, sa_a, 16'h0000);
      lat_miss = lat;
      chk(rdata, w0);
      repeat (6) @(posedge mclk);
      xfer(1'b0, 1'b0, 1'b1, sa_a + 24'h00_0002, 16'h0000);
      chk(rdata, w1);
      chk(16'(lat), 16'(lat_miss - 4));
      xfer(1'b0, 1'b1, 1'b1, sa_a + 24'h00_0004, w0 ^ w1);
      repeat (6) @(posedge mclk);
      xfer(1'b0, 1'b0, 1'b1, sa_a + 24'h00_0004, 16'h0000);
      chk(rdata, w0 ^ w1);
      chk(16'(lat), 16'(lat_miss));
      repeat (6) @(posedge mclk);
      xfer(1'b0, 1'b0, 1'b1, sa_a + 24'h00_0008, 16'h0000);
      chk(16'(lat), 16'(lat_miss));
      pb = 24'h0c_8000 + 24'(16'($random(seed)) & 16'h3ffe);
      xfer(1'b0, 1'b0, 1'b1, pb, 16'h0000);
      chk(rdata, {prom_byte(pb[15:0] + 16'h0001), prom_byte(pb[15:0])});
      // programmed i/o over the same sram; byte lanes must agree with the shared view
      pio(`CSR_CFG_TWO, 1'b1, 1'b1, 16'h2000);
      @(posedge mclk);
      pio_mode <= 1'b1;
      pio(`CSR_SRAM_PTR, 1'b1, 1'b1, offs);
      pio(`CSR_SRAM_DATA, 1'b0, 1'b0, 16'h0000);
      chk({8'h00, rdata[7:0]}, {8'h00, w0[7:0]});
      xfer(1'b1, 1'b0, 1'b0, win + 24'h00_0016, 16'h0000);
      chk({8'h00, rdata[7:0]}, {8'h00, w0[15:8]});
      xfer(1'b1, 1'b1, 1'b1, win + 24'h00_0016, ~w1);
      pio(`CSR_SRAM_PTR, 1'b1, 1'b1, offs + 16'h0002);
      pio(`CSR_SRAM_DATA, 1'b0, 1'b1, 16'h0000);
      chk(rdata, ~w1);
      // the pointer now sits on the prefetched word, so the next data read needs no wait
      repeat (6) @(posedge mclk);
      xfer(1'b1, 1'b0, 1'b1, win + 24'h00_0016, 16'h0000);
      chk(rdata, w0 ^ w1);
      chk(16'(lat), 16'(lat_miss - 4));
      xfer(1'b0, 1'b0, 1'b1, sa_a, 16'h0000);
      chk(rdata, `BUS_FLOAT);
      end_sim();
   end
endmodule : isa_slave_access_and_autoconfig_ports_tb
`default_nettype wire
